// ==== core/eep_pkg.sv ====
package eep_pkg;
	localparam int CLK_MHZ      = 50;
	localparam int ADDR_W_DEF   = 6;
	localparam int WORD_W       = 16;
	localparam int OPC_W        = 2;
	localparam int PROG_TIME_US = 10;
	localparam int PROG_CYC_DEF = PROG_TIME_US * CLK_MHZ;
	localparam int SK_HALF_DEF  = 8;
	localparam logic [1:0] OPC_EXT   = 2'h0;
	localparam logic [1:0] OPC_WRITE = 2'h1;
	localparam logic [1:0] OPC_READ  = 2'h2;
	localparam logic [1:0] OPC_CLEAR = 2'h3;
	localparam logic [1:0] SUB_LOCK   = 2'h0;
	localparam logic [1:0] SUB_FILL   = 2'h1;
	localparam logic [1:0] SUB_UNLOCK = 2'h3;
	localparam int PIN_CS  = 0;
	localparam int PIN_SK  = 1;
	localparam int PIN_DI  = 2;
	localparam int PIN_GRD = 3;
	localparam int PIN_WAL = 4;
	localparam int PIN_N   = 5;
	typedef enum logic [3:0] {
		HOP_READ     = 4'h0,
		HOP_WRITE    = 4'h1,
		HOP_FILL     = 4'h2,
		HOP_LOCK     = 4'h3,
		HOP_UNLOCK   = 4'h4,
		HOP_G_READ   = 4'h5,
		HOP_G_UNLOCK = 4'h6,
		HOP_G_CLEAR  = 4'h7,
		HOP_G_LOAD   = 4'h8,
		HOP_G_FREEZE = 4'h9
	} eep_hop_t;
endpackage

// ==== core/eep_link_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface eep_link_if;
	logic chip_select;
	logic serial_clock_in;
	logic serial_data_in;
	logic guard_reg_access_pin;
	logic write_allow_pin;
	logic serial_data_out_drv;
	logic serial_data_out_oe;
	logic serial_data_out;
	// undriven data out reads as low, like a pulled-down line
	assign serial_data_out = serial_data_out_oe & serial_data_out_drv;
	modport device (
		input  chip_select,
		input  serial_clock_in,
		input  serial_data_in,
		input  guard_reg_access_pin,
		input  write_allow_pin,
		output serial_data_out_drv,
		output serial_data_out_oe
	);
	modport host (
		output chip_select,
		output serial_clock_in,
		output serial_data_in,
		output guard_reg_access_pin,
		output write_allow_pin,
		input  serial_data_out
	);
endinterface
`default_nettype wire

// ==== core/eep_device.sv ====
// Function
// - instruction is start bit, opcode, address, data
// - address is 6 or 8 bits
// - bits move after rising serial clock
// - only active while chip select high
// - read gives dummy zero then 16 bits
// - read continues through following words
// - write is opcode 01, address, 16 bits
// - select fall starts self-timed programming
// - data out rises when programming done
// - write unlock needed before any programming
// - writes to protected addresses are ignored
// - fill writes all words when unprotected
// - write lock blocks programming until unlock
// - guard read shifts out protect address
// - guard unlock must directly precede guard changes
// - guard clear unprotects every word
// - guard load stores protect boundary address
// - guard freeze works once, then locks until system reset
// - boundary address and above are protected
// - guard pin low forbids guard changes
// - write pin low makes array read-only
`timescale 1ns/1ns
`default_nettype none
module eep_device
	import eep_pkg::*;
#(
	parameter int AW          = ADDR_W_DEF,
	parameter int PROG_CYCLES = PROG_CYC_DEF
)(
	// clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	// link
	eep_link_if.device link,
	// status
	output var  logic prog_busy,
	output var  logic writes_unlocked,
	output var  logic guard_frozen
);
	localparam int WORDS = 1 << AW;
	localparam int IW    = OPC_W + AW;
	localparam int TW    = $clog2(PROG_CYCLES + 1);
	localparam logic [TW-1:0] T_LAST = TW'(PROG_CYCLES - 1);
	localparam logic [4:0] CNT_IW = 5'(IW);
	localparam logic [4:0] CNT_W  = 5'(WORD_W);
	localparam logic [4:0] CNT_AW = 5'(AW);

	typedef enum logic [2:0] {
		DS_IDLE  = 3'h0,
		DS_CMD   = 3'h1,
		DS_DATA  = 3'h2,
		DS_RD    = 3'h3,
		DS_ARMED = 3'h4,
		DS_PROG  = 3'h5
	} eep_dstate_t;

	typedef struct packed {
		logic [PIN_N-1:0]  s1;
		logic [PIN_N-1:0]  s2;
		logic [PIN_N-1:0]  s3;
		logic [PIN_N-1:0]  pin;
		eep_dstate_t       state;
		logic [4:0]        cnt;
		logic [IW-1:0]     sh;
		logic [1:0]        opc;
		logic              grd;
		logic [AW-1:0]     adr;
		logic [WORD_W-1:0] word;
		logic              seq;
		logic              go;
		logic [TW-1:0]     timer;
		logic              wr_en;
		logic              g_en;
		logic              g_set;
		logic [AW-1:0]     g_adr;
		logic              frozen;
		logic              do_bit;
		logic              do_oe;
	} eep_dev_st_t;

	eep_dev_st_t st_reg;
	eep_dev_st_t st_next;
	logic [WORD_W-1:0] mem [WORDS];
	logic              mem_we;
	logic              mem_fill;
	logic [PIN_N-1:0]  pins_raw;
	logic [IW-1:0]     inst;
	logic [AW-1:0]     dadr;
	logic              sk_rise;
	logic              cs_fall;
	logic              cs;
	logic              di;
	logic              free_adr;

	assign pins_raw = {link.write_allow_pin, link.guard_reg_access_pin, link.serial_data_in,
		link.serial_clock_in, link.chip_select};
	assign inst = {st_reg.sh[IW-2:0], di};
	assign dadr = inst[AW-1:0];
	// filtered levels move only where stages two and three agree
	assign cs      = st_reg.pin[PIN_CS];
	assign di      = st_reg.s3[PIN_DI];
	assign sk_rise = (st_reg.s2[PIN_SK] == st_reg.s3[PIN_SK]) & st_reg.s3[PIN_SK] & ~st_reg.pin[PIN_SK];
	assign cs_fall = (st_reg.s2[PIN_CS] == st_reg.s3[PIN_CS]) & ~st_reg.s3[PIN_CS] & cs;
	assign free_adr = ~st_reg.g_set | (st_reg.adr < st_reg.g_adr);

	always_comb
	begin
		st_next = st_reg;
		mem_we = 1'b0;
		mem_fill = 1'b0;
		st_next.s1 = pins_raw;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < PIN_N; i++)
		begin
			if (st_reg.s2[i] == st_reg.s3[i])
				st_next.pin[i] = st_reg.s3[i];
		end
		case (st_reg.state)
			DS_IDLE:
			begin
				st_next.do_bit = 1'b1;
				if (cs && sk_rise && di)
				begin
					st_next.state = DS_CMD;
					st_next.cnt = CNT_IW;
					st_next.sh = '0;
					st_next.do_bit = 1'b0;
				end
			end
			DS_CMD:
			begin
				if (sk_rise)
				begin
					st_next.sh = inst;
					st_next.cnt = st_reg.cnt - 5'h01;
					if (st_reg.cnt == 5'h01)
					begin
						st_next.opc = inst[IW-1:AW];
						st_next.adr = dadr;
						st_next.grd = st_reg.pin[PIN_GRD];
						st_next.g_en = 1'b0;
						st_next.state = DS_IDLE;
						st_next.do_bit = 1'b0;
						case (inst[IW-1:AW])
							OPC_READ:
							begin
								st_next.state = DS_RD;
								st_next.seq = ~st_reg.pin[PIN_GRD];
								st_next.cnt = st_reg.pin[PIN_GRD] ? CNT_AW : CNT_W;
								st_next.word = st_reg.pin[PIN_GRD] ? {st_reg.g_adr, {(WORD_W-AW){1'b0}}}
									: mem[dadr];
							end
							OPC_WRITE:
							begin
								st_next.state = st_reg.pin[PIN_GRD] ? DS_ARMED : DS_DATA;
								st_next.cnt = CNT_W;
								st_next.go = st_reg.g_en & st_reg.wr_en & ~st_reg.frozen;
							end
							OPC_CLEAR:
							begin
								if (st_reg.pin[PIN_GRD] && dadr == {AW{1'b1}})
								begin
									st_next.state = DS_ARMED;
									st_next.go = st_reg.g_en & st_reg.wr_en & ~st_reg.frozen;
								end
							end
							default:
							begin
								case (dadr[AW-1:AW-2])
									SUB_UNLOCK:
									begin
										if (st_reg.pin[PIN_WAL] && st_reg.pin[PIN_GRD])
											st_next.g_en = 1'b1;
										else if (st_reg.pin[PIN_WAL])
											st_next.wr_en = 1'b1;
									end
									SUB_FILL:
									begin
										if (!st_reg.pin[PIN_GRD])
										begin
											st_next.state = DS_DATA;
											st_next.cnt = CNT_W;
										end
									end
									SUB_LOCK:
									begin
										if (!st_reg.pin[PIN_GRD])
											st_next.wr_en = 1'b0;
										else if (dadr == '0)
										begin
											st_next.state = DS_ARMED;
											st_next.go = st_reg.g_en & st_reg.wr_en & ~st_reg.frozen;
										end
									end
									default:
									begin
										st_next.state = DS_IDLE;
									end
								endcase
							end
						endcase
					end
				end
			end
			DS_DATA:
			begin
				if (sk_rise)
				begin
					st_next.word = {st_reg.word[WORD_W-2:0], di};
					st_next.cnt = st_reg.cnt - 5'h01;
					if (st_reg.cnt == 5'h01)
					begin
						st_next.state = DS_ARMED;
						// fill needs a cleared guard, a single write an unprotected word
						st_next.go = st_reg.wr_en & st_reg.pin[PIN_WAL]
							& ((st_reg.opc == OPC_EXT) ? ~st_reg.g_set : free_adr);
					end
				end
			end
			DS_RD:
			begin
				if (sk_rise)
				begin
					if (st_reg.cnt != 5'h00)
					begin
						st_next.do_bit = st_reg.word[WORD_W-1];
						st_next.word = {st_reg.word[WORD_W-2:0], 1'b0};
						st_next.cnt = st_reg.cnt - 5'h01;
					end
					else if (st_reg.seq)
					begin
						st_next.adr = st_reg.adr + 1'b1;
						st_next.do_bit = mem[st_next.adr][WORD_W-1];
						st_next.word = {mem[st_next.adr][WORD_W-2:0], 1'b0};
						st_next.cnt = CNT_W - 5'h01;
					end
					else
						st_next.state = DS_IDLE;
				end
			end
			DS_ARMED:
			begin
				st_next.do_bit = 1'b0;
				if (cs_fall)
				begin
					st_next.state = st_reg.go ? DS_PROG : DS_IDLE;
					st_next.timer = T_LAST;
				end
			end
			DS_PROG:
			begin
				st_next.do_bit = 1'b0;
				st_next.timer = st_reg.timer - 1'b1;
				if (st_reg.timer == '0)
				begin
					st_next.state = DS_IDLE;
					st_next.do_bit = 1'b1;
					if (!st_reg.grd)
					begin
						mem_we = 1'b1;
						mem_fill = (st_reg.opc == OPC_EXT);
					end
					else if (st_reg.opc == OPC_EXT)
						st_next.frozen = 1'b1;
					else
					begin
						st_next.g_set = (st_reg.opc == OPC_WRITE);
						st_next.g_adr = (st_reg.opc == OPC_WRITE) ? st_reg.adr : {AW{1'b1}};
					end
				end
			end
			default:
			begin
				st_next.state = DS_IDLE;
			end
		endcase
		// a half-shifted instruction dies with chip select
		if (cs_fall && st_reg.state != DS_ARMED && st_reg.state != DS_PROG)
			st_next.state = DS_IDLE;
		st_next.do_oe = st_next.pin[PIN_CS];
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_reg <= '0;
			st_reg.g_adr <= {AW{1'b1}};
		end
		else if (clk_en)
			st_reg <= st_next;
	end

	// array holds no reset: its contents stand for non-volatile cells
	always_ff @(posedge clk)
	begin
		if (clk_en && mem_we)
		begin
			for (int i = 0; i < WORDS; i++)
			begin
				if (mem_fill || st_reg.adr == AW'(i))
					mem[i] <= st_reg.word;
			end
		end
	end

	assign link.serial_data_out_drv = st_reg.do_bit;
	assign link.serial_data_out_oe  = st_reg.do_oe;
	assign prog_busy       = (st_reg.state == DS_PROG);
	assign writes_unlocked = st_reg.wr_en;
	assign guard_frozen    = st_reg.frozen;
endmodule
`default_nettype wire

// ==== core/eep_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module eep_host
	import eep_pkg::*;
#(
	parameter int AW      = ADDR_W_DEF,
	parameter int SK_HALF = SK_HALF_DEF
)(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              clk_en,
	// command
	input  wire logic              cmd_req,
	input  wire eep_hop_t          cmd_op,
	input  wire logic [AW-1:0]     cmd_addr,
	input  wire logic [WORD_W-1:0] cmd_data,
	input  wire logic              allow_writes,
	input  wire logic              allow_guard,
	output var  logic              busy,
	output var  logic              done,
	output var  logic              rd_valid,
	output var  logic [WORD_W-1:0] rd_data,
	// link
	eep_link_if.host link
);
	localparam int FW = 1 + OPC_W + AW + WORD_W;
	localparam int HW = $clog2(SK_HALF + 1);
	localparam logic [HW-1:0] H_LAST = HW'(SK_HALF - 1);
	localparam logic [5:0] N_CMD = 6'(1 + OPC_W + AW);
	localparam logic [5:0] N_RDW = 6'(1 + WORD_W);
	localparam logic [5:0] N_RDG = 6'(1 + AW);

	typedef enum logic [2:0] {
		HS_IDLE  = 3'h0,
		HS_SHIFT = 3'h1,
		HS_RDIN  = 3'h2,
		HS_GAP   = 3'h3,
		HS_POLL  = 3'h4
	} eep_hstate_t;

	typedef struct packed {
		eep_hstate_t       state;
		logic [FW-1:0]     frame;
		logic [5:0]        cnt;
		logic [5:0]        rcnt;
		logic [WORD_W:0]   rsh;
		logic [HW-1:0]     ph;
		logic              is_rd;
		logic              is_prog;
		logic              cs;
		logic              sk;
		logic              di;
		logic              pre;
		logic              pe;
		logic [2:0]        dsync;
		logic              dof;
		logic              busy;
		logic              done;
		logic              rd_valid;
		logic [WORD_W-1:0] rd_data;
	} eep_host_st_t;

	eep_host_st_t st_reg;
	eep_host_st_t st_next;
	logic [1:0]    opc;
	logic [AW-1:0] adr;
	logic          has_data;
	logic          grd_op;

	always_comb
	begin
		opc = OPC_EXT;
		adr = '0;
		has_data = 1'b0;
		grd_op = 1'b0;
		case (cmd_op)
			HOP_READ:     begin opc = OPC_READ; adr = cmd_addr; end
			HOP_WRITE:    begin opc = OPC_WRITE; adr = cmd_addr; has_data = 1'b1; end
			HOP_FILL:     begin adr = {SUB_FILL, {(AW-2){1'b0}}}; has_data = 1'b1; end
			HOP_LOCK:     begin adr = {SUB_LOCK, {(AW-2){1'b0}}}; end
			HOP_UNLOCK:   begin adr = {SUB_UNLOCK, {(AW-2){1'b0}}}; end
			HOP_G_READ:   begin opc = OPC_READ; grd_op = 1'b1; end
			HOP_G_UNLOCK: begin adr = {SUB_UNLOCK, {(AW-2){1'b0}}}; grd_op = 1'b1; end
			HOP_G_CLEAR:  begin opc = OPC_CLEAR; adr = {AW{1'b1}}; grd_op = 1'b1; end
			HOP_G_LOAD:   begin opc = OPC_WRITE; adr = cmd_addr; grd_op = 1'b1; end
			HOP_G_FREEZE: begin grd_op = 1'b1; end
			default:      begin opc = OPC_EXT; end
		endcase
	end

	always_comb
	begin
		st_next = st_reg;
		st_next.done = 1'b0;
		st_next.rd_valid = 1'b0;
		st_next.dsync = {st_reg.dsync[1:0], link.serial_data_out};
		if (st_reg.dsync[1] == st_reg.dsync[2])
			st_next.dof = st_reg.dsync[2];
		st_next.ph = (st_reg.ph == '0) ? H_LAST : st_reg.ph - 1'b1;
		case (st_reg.state)
			HS_IDLE:
			begin
				st_next.ph = H_LAST;
				if (cmd_req)
				begin
					st_next.state = HS_SHIFT;
					st_next.busy = 1'b1;
					st_next.frame = {1'b1, opc, adr, has_data ? cmd_data : {WORD_W{1'b0}}};
					st_next.cnt = N_CMD + (has_data ? 6'(WORD_W) : 6'h00);
					st_next.is_rd = (opc == OPC_READ);
					st_next.rcnt = grd_op ? N_RDG : N_RDW;
					st_next.is_prog = has_data | (grd_op & opc != OPC_READ & cmd_op != HOP_G_UNLOCK);
					st_next.pre = grd_op & allow_guard;
					st_next.pe = allow_writes & (opc != OPC_READ);
					st_next.cs = 1'b1;
					st_next.sk = 1'b0;
					st_next.di = 1'b1;
					st_next.rsh = '0;
				end
			end
			HS_SHIFT:
			begin
				if (st_reg.ph == '0)
				begin
					st_next.sk = ~st_reg.sk;
					if (st_reg.sk)
					begin
						st_next.frame = {st_reg.frame[FW-2:0], 1'b0};
						st_next.di = st_reg.frame[FW-2];
						st_next.cnt = st_reg.cnt - 6'h01;
						if (st_reg.cnt == 6'h01)
						begin
							st_next.state = st_reg.is_rd ? HS_RDIN : HS_GAP;
							st_next.cs = st_reg.is_rd;
						end
					end
				end
			end
			HS_RDIN:
			begin
				if (st_reg.ph == '0)
				begin
					if (!st_reg.sk)
					begin
						// sample just before the rise, a full period after the rise that moved the bit
						st_next.rsh = {st_reg.rsh[WORD_W-1:0], st_reg.dof};
						st_next.rcnt = st_reg.rcnt - 6'h01;
						st_next.sk = (st_reg.rcnt != 6'h01);
						if (st_reg.rcnt == 6'h01)
						begin
							// select must stay low long enough for the far synchroniser to end the read
							st_next.state = HS_GAP;
							st_next.cs = 1'b0;
							st_next.rd_data = {st_reg.rsh[WORD_W-2:0], st_reg.dof};
						end
					end
					else
						st_next.sk = 1'b0;
				end
			end
			HS_GAP:
			begin
				if (st_reg.ph == '0)
				begin
					st_next.state = st_reg.is_prog ? HS_POLL : HS_IDLE;
					st_next.cs = st_reg.is_prog;
					st_next.busy = st_reg.is_prog;
					st_next.done = ~st_reg.is_prog;
					st_next.rd_valid = st_reg.is_rd & ~st_reg.is_prog;
				end
			end
			HS_POLL:
			begin
				// a refused instruction reads ready at once, so this wait ends
				if (st_reg.dof && st_reg.ph == '0)
				begin
					// a low gap before done, so the next frame starts on a clean select
					st_next.state = HS_GAP;
					st_next.is_prog = 1'b0;
					st_next.cs = 1'b0;
				end
			end
			default:
			begin
				st_next.state = HS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			st_reg <= '0;
		else if (clk_en)
			st_reg <= st_next;
	end

	assign link.chip_select          = st_reg.cs;
	assign link.serial_clock_in      = st_reg.sk;
	assign link.serial_data_in       = st_reg.di;
	assign link.guard_reg_access_pin = st_reg.pre;
	assign link.write_allow_pin      = st_reg.pe;
	assign busy     = st_reg.busy;
	assign done     = st_reg.done;
	assign rd_valid = st_reg.rd_valid;
	assign rd_data  = st_reg.rd_data;
endmodule
`default_nettype wire

// ==== testbench/eep_link_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
module eep_link_properties (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// link
	input wire logic chip_select,
	input wire logic serial_clock_in,
	input wire logic serial_data_in,
	input wire logic guard_reg_access_pin,
	input wire logic write_allow_pin,
	input wire logic serial_data_out_drv,
	input wire logic serial_data_out_oe,
	input wire logic serial_data_out
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// six cycles leave room for the device's select synchroniser
	out_off_a: assert property (!chip_select [*6] |-> !serial_data_out_oe)
		else $error("data out driven while deselected");
	out_on_a: assert property (chip_select [*6] |-> serial_data_out_oe)
		else $error("data out not driven while selected");
	clk_in_frame_a: assert property ($rose(serial_clock_in) |-> chip_select)
		else $error("serial clock rose while deselected");
	select_clk_low_a: assert property ($rose(chip_select) |-> !serial_clock_in)
		else $error("select rose with serial clock high");
	di_hold_a: assert property (serial_clock_in && $past(serial_clock_in) |-> $stable(serial_data_in))
		else $error("data in moved while serial clock high");
	// phase length fixed at the bench value of 8 clk cycles
	sk_high_a: assert property ($rose(serial_clock_in) |-> serial_clock_in [*8])
		else $error("serial clock high phase too short");
	sk_low_a: assert property ($fell(serial_clock_in) |-> !serial_clock_in [*8])
		else $error("serial clock low phase too short");
	pins_steady_a: assert property (chip_select && $past(chip_select)
		|-> $stable(write_allow_pin) && $stable(guard_reg_access_pin))
		else $error("control pins moved within a frame");
	cover property ($rose(serial_data_out));
	cover property ($rose(chip_select) && guard_reg_access_pin);
	cover property ($rose(chip_select) && !write_allow_pin);
endmodule
`default_nettype wire

// ==== testbench/serial_eeprom_protect_cmd_port_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_protect_cmd_port_tb_top;
	import eep_pkg::*;
	localparam int AW = 6;
	logic              clk = 1'b0;
	logic              sys_rst = 1'b1;
	logic              cmd_req = 1'b0;
	eep_hop_t          cmd_op = HOP_READ;
	logic [AW-1:0]     cmd_addr = '0;
	logic [WORD_W-1:0] cmd_data = '0;
	logic              allow_writes = 1'b1;
	logic              allow_guard = 1'b1;
	logic              busy, done, rd_valid, prog_busy, unlocked, frozen;
	logic [WORD_W-1:0] rd_data;
	int                fails = 0;
	int                n_tests = 0;
	eep_link_if lk ();
	always #10 clk = ~clk;
	eep_host #(.AW(AW), .SK_HALF(8)) i_eep_host (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
		.cmd_req(cmd_req), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.allow_writes(allow_writes), .allow_guard(allow_guard), .busy(busy), .done(done),
		.rd_valid(rd_valid), .rd_data(rd_data), .link(lk.host));
	// short programming time keeps the run brief
	eep_device #(.AW(AW), .PROG_CYCLES(20)) i_eep_device (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
		.link(lk.device), .prog_busy(prog_busy), .writes_unlocked(unlocked), .guard_frozen(frozen));
	eep_link_properties i_eep_link_properties (.clk(clk), .sys_rst(sys_rst),
		.chip_select(lk.chip_select), .serial_clock_in(lk.serial_clock_in),
		.serial_data_in(lk.serial_data_in), .guard_reg_access_pin(lk.guard_reg_access_pin),
		.write_allow_pin(lk.write_allow_pin), .serial_data_out_drv(lk.serial_data_out_drv),
		.serial_data_out_oe(lk.serial_data_out_oe), .serial_data_out(lk.serial_data_out));
	task automatic chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// called just after an edge; returns just after the edge that shows done
	task automatic op(input eep_hop_t o, input logic [AW-1:0] a, input logic [WORD_W-1:0] d);
		int n;
		cmd_op = o;
		cmd_addr = a;
		cmd_data = d;
		cmd_req = 1'b1;
		@(posedge clk);
		#1;
		cmd_req = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 3000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 3000)
		begin
			fails++;
			test_done;
		end
	endtask
	task automatic rd(input eep_hop_t o, input logic [AW-1:0] a, input logic [WORD_W-1:0] e);
		op(o, a, '0);
		chk({15'h0, rd_valid}, 16'h0001);
		chk({15'h0, busy}, 16'h0000);
		chk(o == HOP_G_READ ? {{(WORD_W-AW){1'b0}}, rd_data[AW-1:0]} : rd_data, e);
	endtask
	task automatic tend(input string name);
		$display("test %s finished", name);
	endtask
	initial
	begin
		repeat (40000) @(posedge clk);
		fails++;
		test_done;
	end
	initial
	begin
		repeat (2) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		op(HOP_UNLOCK, 6'h30, '0);
		chk({15'h0, unlocked}, 16'h0001);
		op(HOP_FILL, 6'h10, 16'h5a5a);
		rd(HOP_READ, 6'h03, 16'h5a5a);
		rd(HOP_READ, 6'h3f, 16'h5a5a);
		op(HOP_WRITE, 6'h05, 16'ha1b2);
		chk({15'h0, prog_busy}, 16'h0000);
		rd(HOP_READ, 6'h05, 16'ha1b2);
		tend("fill and write");
		op(HOP_LOCK, 6'h00, '0);
		chk({15'h0, unlocked}, 16'h0000);
		op(HOP_WRITE, 6'h05, 16'hffff);
		rd(HOP_READ, 6'h05, 16'ha1b2);
		op(HOP_UNLOCK, 6'h30, '0);
		allow_writes = 1'b0;
		op(HOP_WRITE, 6'h06, 16'h1234);
		allow_writes = 1'b1;
		rd(HOP_READ, 6'h06, 16'h5a5a);
		tend("lock and write pin");
		op(HOP_G_UNLOCK, 6'h30, '0);
		op(HOP_G_LOAD, 6'h08, '0);
		rd(HOP_G_READ, 6'h00, 16'h0008);
		op(HOP_WRITE, 6'h08, 16'h0001);
		rd(HOP_READ, 6'h08, 16'h5a5a);
		op(HOP_WRITE, 6'h07, 16'h0002);
		rd(HOP_READ, 6'h07, 16'h0002);
		op(HOP_FILL, 6'h10, 16'h0000);
		rd(HOP_READ, 6'h07, 16'h0002);
		op(HOP_G_LOAD, 6'h04, '0);
		rd(HOP_G_READ, 6'h00, 16'h0008);
		tend("protect boundary");
		op(HOP_G_UNLOCK, 6'h30, '0);
		op(HOP_G_CLEAR, 6'h3f, '0);
		rd(HOP_G_READ, 6'h00, 16'h003f);
		op(HOP_WRITE, 6'h3e, 16'hbeef);
		rd(HOP_READ, 6'h3e, 16'hbeef);
		allow_guard = 1'b0;
		op(HOP_G_UNLOCK, 6'h30, '0);
		op(HOP_G_LOAD, 6'h02, '0);
		allow_guard = 1'b1;
		rd(HOP_G_READ, 6'h00, 16'h003f);
		op(HOP_G_UNLOCK, 6'h30, '0);
		op(HOP_G_FREEZE, 6'h00, '0);
		chk({15'h0, frozen}, 16'h0001);
		op(HOP_G_UNLOCK, 6'h30, '0);
		op(HOP_G_LOAD, 6'h02, '0);
		rd(HOP_G_READ, 6'h00, 16'h003f);
		tend("protect register");
		test_done;
	end
endmodule
`default_nettype wire
